// >>> logic/btr_regs.svh
// Constants for the bit test / invert / rotate execution block.
// Assumes inclusion by bare name from design files only.
`ifndef BTR_REGS_SVH
`define BTR_REGS_SVH
`define BTR_OP5_SKIP     5'h12
`define BTR_OP5_INV      5'h07
`define BTR_OP7_RLNC     7'h11
`define BTR_OP7_RRC      7'h0C
`define BTR_OP5_MSB      15
`define BTR_OP5_LSB      11
`define BTR_OP7_LSB      9
`define BTR_BIT_MSB      10
`define BTR_BIT_LSB      8
`define BTR_DEST_BIT     8
`define BTR_ADDR_MSB     7
`define BTR_PH_DECODE    2'h0
`define BTR_PH_READ      2'h1
`define BTR_PH_PROC      2'h2
`define BTR_PH_WRITE     2'h3
`define BTR_BYTE_RST     8'h00
`endif

// >>> logic/btr_pkg.sv
// Types shared by the execution block.
// Assumes the constants header is compiled alongside.
package btr_pkg;
    typedef enum logic [4:0] {
        BTR_NONE = 5'h01,
        BTR_SKIP = 5'h02,
        BTR_INV  = 5'h04,
        BTR_RLNC = 5'h08,
        BTR_RRC  = 5'h10
    } btr_op_t;
endpackage

// >>> logic/btr_decode.sv
// Instruction word decoder for the four supported operations.
// Assumes a stable 16-bit word during the decode quarter.
`timescale 1ns/10ps
`include "btr_regs.svh"
module btr_decode (
    input  wire logic [15:0]   instr_i,
    output btr_pkg::btr_op_t   op_o,
    output logic      [2:0]    bit_o,
    output logic               dest_o,
    output logic      [7:0]    addr_o
);
    logic [4:0] top5;
    logic [6:0] top7;
    always_comb begin
        top5   = instr_i[`BTR_OP5_MSB:`BTR_OP5_LSB];
        top7   = instr_i[`BTR_OP5_MSB:`BTR_OP7_LSB];
        bit_o  = instr_i[`BTR_BIT_MSB:`BTR_BIT_LSB];
        dest_o = instr_i[`BTR_DEST_BIT];
        addr_o = instr_i[`BTR_ADDR_MSB:0];
        if (top5 == `BTR_OP5_SKIP) begin
            op_o = btr_pkg::BTR_SKIP;
        end else if (top5 == `BTR_OP5_INV) begin
            op_o = btr_pkg::BTR_INV;
        end else if (top7 == `BTR_OP7_RLNC) begin
            op_o = btr_pkg::BTR_RLNC;
        end else if (top7 == `BTR_OP7_RRC) begin
            op_o = btr_pkg::BTR_RRC;
        end else begin
            op_o = btr_pkg::BTR_NONE;
        end
    end
endmodule

// >>> logic/btr_exec.sv
// Functional notes
// - Set bit discards next instruction, executes nop.
// - Decode bit invert from top bits 00111.
// - Decode rotate-left-no-carry from top 0010001.
// - Left rotate wraps bit 7, carry untouched.
// - Decode rotate-right-carry from top 0001100.
// - Right rotate through carry; d selects destination.
// - Quarters: decode, read, process, write.
//
// Execution datapath stepping one quarter per clock.
// Assumes the file returns read data combinationally on the read quarter.
`timescale 1ns/10ps
`include "btr_regs.svh"
module btr_exec (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [15:0] instr_i,
    input  wire logic [7:0]  file_rdata_i,
    input  wire logic        carry_i,
    output logic      [1:0]  phase_o,
    output logic             file_re_o,
    output logic      [7:0]  file_addr_o,
    output logic             file_we_o,
    output logic      [7:0]  file_wdata_o,
    output logic             working_register_we_o,
    output logic      [7:0]  working_register_wdata_o,
    output logic             carry_we_o,
    output logic             carry_o,
    output logic             skip_o
);
    btr_pkg::btr_op_t dec_op;
    logic [2:0]       dec_bit;
    logic             dec_dest;
    logic [7:0]       dec_addr;

    btr_decode u_dec (
        .instr_i (instr_i),
        .op_o    (dec_op),
        .bit_o   (dec_bit),
        .dest_o  (dec_dest),
        .addr_o  (dec_addr)
    );

    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        bit_mask = 8'h01 << b;
    endfunction

    btr_pkg::btr_op_t op_q, op_d;
    logic [1:0]  ph_q, ph_d;
    logic [2:0]  bit_q, bit_d;
    logic        dest_q, dest_d;
    logic [7:0]  addr_q, addr_d;
    logic [7:0]  opnd_q, opnd_d;
    logic [7:0]  res_q, res_d;
    logic        cres_q, cres_d;
    logic        nop_q, nop_d;
    logic        re_q, re_d, fwe_q, fwe_d, wwe_q, wwe_d, cwe_q, cwe_d, skip_q, skip_d;

    always_comb begin
        ph_d   = ph_q + 2'h1;
        op_d   = op_q;
        bit_d  = bit_q;
        dest_d = dest_q;
        addr_d = addr_q;
        opnd_d = opnd_q;
        res_d  = res_q;
        cres_d = cres_q;
        nop_d  = nop_q;
        re_d   = 1'b0;
        fwe_d  = 1'b0;
        wwe_d  = 1'b0;
        cwe_d  = 1'b0;
        skip_d = 1'b0;
        case (ph_q)
            `BTR_PH_DECODE: begin
                // Discarded word becomes a nop cycle
                if (nop_q) begin
                    op_d = btr_pkg::BTR_NONE;
                end else begin
                    op_d = dec_op;
                end
                nop_d  = 1'b0;
                bit_d  = dec_bit;
                dest_d = dec_dest;
                addr_d = dec_addr;
                re_d   = !nop_q && (dec_op != btr_pkg::BTR_NONE);
            end
            `BTR_PH_READ: begin
                opnd_d = file_rdata_i;
            end
            `BTR_PH_PROC: begin
                cres_d = carry_i;
                case (op_q)
                    btr_pkg::BTR_INV: begin
                        res_d = opnd_q ^ bit_mask(bit_q);
                    end
                    btr_pkg::BTR_RLNC: begin
                        res_d = {opnd_q[6:0], opnd_q[7]};
                    end
                    btr_pkg::BTR_RRC: begin
                        res_d  = {carry_i, opnd_q[7:1]};
                        cres_d = opnd_q[0];
                    end
                    btr_pkg::BTR_SKIP: begin
                        nop_d = |(opnd_q & bit_mask(bit_q));
                        res_d = opnd_q;
                    end
                    default: begin
                        res_d = opnd_q;
                    end
                endcase
                // Write strobes drive during the write quarter
                fwe_d = (op_q == btr_pkg::BTR_INV) ||
                        ((op_q == btr_pkg::BTR_RLNC || op_q == btr_pkg::BTR_RRC)
                         && dest_q);
                wwe_d = (op_q == btr_pkg::BTR_RLNC || op_q == btr_pkg::BTR_RRC)
                        && !dest_q;
                cwe_d = (op_q == btr_pkg::BTR_RRC);
                skip_d = (op_q == btr_pkg::BTR_SKIP)
                         && |(opnd_q & bit_mask(bit_q));
            end
            `BTR_PH_WRITE: begin
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ph_q   <= `BTR_PH_DECODE;
            op_q   <= btr_pkg::BTR_NONE;
            bit_q  <= 3'h0;
            dest_q <= 1'b0;
            addr_q <= `BTR_BYTE_RST;
            opnd_q <= `BTR_BYTE_RST;
            res_q  <= `BTR_BYTE_RST;
            cres_q <= 1'b0;
            nop_q  <= 1'b0;
            re_q   <= 1'b0;
            fwe_q  <= 1'b0;
            wwe_q  <= 1'b0;
            cwe_q  <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            ph_q   <= ph_d;
            op_q   <= op_d;
            bit_q  <= bit_d;
            dest_q <= dest_d;
            addr_q <= addr_d;
            opnd_q <= opnd_d;
            res_q  <= res_d;
            cres_q <= cres_d;
            nop_q  <= nop_d;
            re_q   <= re_d;
            fwe_q  <= fwe_d;
            wwe_q  <= wwe_d;
            cwe_q  <= cwe_d;
            skip_q <= skip_d;
        end
    end

    assign phase_o      = ph_q;
    assign file_re_o    = re_q;
    assign file_addr_o  = addr_q;
    assign file_we_o    = fwe_q;
    assign file_wdata_o = res_q;
    assign working_register_we_o    = wwe_q;
    assign working_register_wdata_o = res_q;
    assign carry_we_o   = cwe_q;
    assign carry_o      = cres_q;
    assign skip_o       = skip_q;

    a_phase_walk: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ph_q == `BTR_PH_DECODE |=> ph_q == `BTR_PH_READ ##1 ph_q == `BTR_PH_PROC
        ##1 ph_q == `BTR_PH_WRITE) else $error("phase order broken");
    a_read_phase: assert property (@(posedge clk_i) disable iff (!rstn_i)
        re_q |-> ph_q == `BTR_PH_READ)
        else $error("read outside read quarter");
    a_write_phase: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (fwe_q || wwe_q || cwe_q) |-> ph_q == `BTR_PH_WRITE)
        else $error("write outside write quarter");
    a_invert_one: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (fwe_q && op_q == btr_pkg::BTR_INV) |-> $countones(res_q ^ opnd_q) == 1)
        else $error("invert changed wrong bits");
    a_rlnc_rot: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ((fwe_q || wwe_q) && op_q == btr_pkg::BTR_RLNC) |->
        res_q == {opnd_q[6:0], opnd_q[7]} && !cwe_q)
        else $error("left rotate wrong");
    a_rrc_rot: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (cwe_q) |-> res_q[6:0] == opnd_q[7:1] && carry_o == opnd_q[0])
        else $error("right rotate wrong");
    a_rrc_carry_in: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cwe_q |-> res_q[7] == $past(carry_i))
        else $error("old carry not rotated in");
    a_flag_only_rrc: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cwe_q |-> op_q == btr_pkg::BTR_RRC)
        else $error("flag written by wrong op");
    a_skip_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
        skip_q |-> !fwe_q && !wwe_q && !cwe_q)
        else $error("skip wrote a destination");
    a_dest_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wwe_q |-> !dest_q && !fwe_q)
        else $error("destination select wrong");
    // Decode quarter after the pulse still holds the skip op, so start one later
    a_skip_nop: assert property (@(posedge clk_i) disable iff (!rstn_i)
        skip_q |=> ##1 (op_q == btr_pkg::BTR_NONE && !re_q && !fwe_q && !wwe_q) [*4])
        else $error("skipped word executed");
    a_decode_inv: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ph_q == `BTR_PH_DECODE && !nop_q && instr_i[15:11] == `BTR_OP5_INV)
        |=> op_q == btr_pkg::BTR_INV) else $error("invert decode");
    a_decode_skip: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ph_q == `BTR_PH_DECODE && !nop_q && instr_i[15:11] == `BTR_OP5_SKIP)
        |=> op_q == btr_pkg::BTR_SKIP) else $error("skip decode");
    a_decode_rot: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ph_q == `BTR_PH_DECODE && !nop_q && instr_i[15:9] == `BTR_OP7_RLNC)
        |=> op_q == btr_pkg::BTR_RLNC) else $error("rotate decode");
    a_decode_rrc: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ph_q == `BTR_PH_DECODE && !nop_q && instr_i[15:9] == `BTR_OP7_RRC)
        |=> op_q == btr_pkg::BTR_RRC) else $error("rrc decode");

    c_skip: cover property (@(posedge clk_i) skip_q);
    c_invert: cover property (@(posedge clk_i) fwe_q && op_q == btr_pkg::BTR_INV);
    c_rrc_file: cover property (@(posedge clk_i) cwe_q && fwe_q);
    c_rlnc_working_register: cover property (@(posedge clk_i) wwe_q && op_q == btr_pkg::BTR_RLNC);
endmodule

// >>> test/btr_file_model.sv
// Data file, carry flag and working register on the far side of the block.
// Assumes reads are answered at once while the read strobe is high.
`timescale 1ns/10ps
module btr_file_model (
    input  wire logic       clk_i,
    input  wire logic       file_re_i,
    input  wire logic [7:0] file_addr_i,
    input  wire logic       file_we_i,
    input  wire logic [7:0] file_wdata_i,
    input  wire logic       working_register_we_i,
    input  wire logic [7:0] working_register_wdata_i,
    input  wire logic       carry_we_i,
    input  wire logic       carry_i,
    output logic      [7:0] file_rdata_o,
    output logic            carry_o
);
    logic [7:0] mem [0:255];
    logic [7:0] working_register_q;
    logic       carry_q;
    // Unread bus shows inverted data, so a stray sample never matches
    assign file_rdata_o = file_re_i ? mem[file_addr_i] : ~mem[file_addr_i];
    assign carry_o      = carry_q;
    always @(posedge clk_i) begin
        if (file_we_i) mem[file_addr_i] <= file_wdata_i;
        if (working_register_we_i) working_register_q <= working_register_wdata_i;
        if (carry_we_i) carry_q <= carry_i;
    end
endmodule

// >>> test/tb_btr_exec.sv
// Self-checking bench for the execution block and its file model.
// Assumes one instruction per four-quarter cycle, read strobe in quarter 1, write strobes in quarter 3.
`timescale 1ns/10ps
`define CHK(a, e) begin \
    checked++; \
    if ((a) !== (e)) begin \
        bad_count++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
end
module tb_btr_exec;
    logic        clk_i, rstn_i, carry_i, file_re_o, file_we_o, working_register_we_o, carry_we_o;
    logic        carry_o, skip_o, re_seen;
    logic [15:0] instr_i;
    logic [7:0]  file_rdata_i, file_addr_o, file_wdata_o, working_register_wdata_o;
    logic [1:0]  phase_o;
    int          bad_count, checked;
    btr_exec btr_exec_i (.clk_i(clk_i), .rstn_i(rstn_i), .instr_i(instr_i),
        .file_rdata_i(file_rdata_i), .carry_i(carry_i), .phase_o(phase_o),
        .file_re_o(file_re_o), .file_addr_o(file_addr_o), .file_we_o(file_we_o),
        .file_wdata_o(file_wdata_o), .working_register_we_o(working_register_we_o), .working_register_wdata_o(working_register_wdata_o),
        .carry_we_o(carry_we_o), .carry_o(carry_o), .skip_o(skip_o));
    btr_file_model btr_file_model_i (.clk_i(clk_i), .file_re_i(file_re_o),
        .file_addr_i(file_addr_o), .file_we_i(file_we_o), .file_wdata_i(file_wdata_o),
        .working_register_we_i(working_register_we_o), .working_register_wdata_i(working_register_wdata_o), .carry_we_i(carry_we_o),
        .carry_i(carry_o), .file_rdata_o(file_rdata_i), .carry_o(carry_i));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Lets pending writes land, then stops in the decode quarter
    task automatic sync0();
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        while (phase_o !== 2'h0) begin
            n++;
            if (n > 8) begin
                bad_count++;
                results();
            end
            @(posedge clk_i);
            #1;
        end
    endtask
    // Offers one word, returns in quarter 3 with strobes standing
    task automatic exec_op(input logic [15:0] w);
        instr_i = w;
        @(posedge clk_i);
        #1;
        re_seen = file_re_o;
        `CHK(phase_o, 2'h1)
        repeat (2) @(posedge clk_i);
        #1;
        `CHK(phase_o, 2'h3)
    endtask
    task automatic t_invert();
        for (int b = 0; b < 8; b++) begin
            sync0();
            btr_file_model_i.mem[8'h20] = 8'h75;
            exec_op({5'h07, 3'(b), 8'h20});
            `CHK(re_seen, 1'b1)
            `CHK(file_addr_o, 8'h20)
            `CHK({file_we_o, working_register_we_o, carry_we_o, skip_o}, 4'h8)
            `CHK(file_wdata_o, 8'h75 ^ (8'h01 << b))
        end
        $display("test invert done");
    endtask
    task automatic t_rlnc();
        for (int d = 0; d < 2; d++) begin
            sync0();
            btr_file_model_i.mem[8'h31] = 8'hEB;
            exec_op({7'h11, 1'(d), 8'h31});
            `CHK({file_we_o, working_register_we_o}, d ? 2'h2 : 2'h1)
            `CHK(d ? file_wdata_o : working_register_wdata_o, 8'hD7)
            `CHK({carry_we_o, skip_o}, 2'h0)
        end
        // Let the last write land, then look at the far side
        sync0();
        `CHK(btr_file_model_i.working_register_q, 8'hD7)
        `CHK(btr_file_model_i.mem[8'h31], 8'hD7)
        $display("test rotate left done");
    endtask
    task automatic t_rrc();
        logic [7:0] v;
        for (int k = 0; k < 4; k++) begin
            v = k[1] ? 8'hE7 : 8'hE6;
            sync0();
            btr_file_model_i.mem[8'h42] = v;
            btr_file_model_i.carry_q = k[0];
            exec_op({7'h0C, k[1], 8'h42});
            `CHK({file_we_o, working_register_we_o}, k[1] ? 2'h2 : 2'h1)
            `CHK(k[1] ? file_wdata_o : working_register_wdata_o, {k[0], v[7:1]})
            `CHK({carry_we_o, carry_o, skip_o}, {1'b1, v[0], 1'b0})
        end
        sync0();
        `CHK(btr_file_model_i.working_register_q, 8'hF3)
        `CHK(btr_file_model_i.mem[8'h42], 8'hF3)
        `CHK(btr_file_model_i.carry_q, 1'b1)
        $display("test rotate right done");
    endtask
    task automatic t_skip();
        sync0();
        btr_file_model_i.mem[8'h50] = 8'h02;
        exec_op({5'h12, 3'h1, 8'h50});
        `CHK({skip_o, file_we_o, working_register_we_o, carry_we_o}, 4'h8)
        sync0();
        exec_op({5'h07, 3'h0, 8'h50});
        // Discarded word: no read, no write of any kind
        `CHK({re_seen, file_we_o, working_register_we_o, carry_we_o}, 4'h0)
        sync0();
        exec_op({5'h07, 3'h0, 8'h50});
        `CHK({file_we_o, file_wdata_o}, 9'h103)
        sync0();
        exec_op({5'h12, 3'h2, 8'h50});
        `CHK({skip_o, file_we_o, working_register_we_o, carry_we_o}, 4'h0)
        sync0();
        exec_op(16'hFFFF);
        `CHK({skip_o, file_we_o, working_register_we_o, carry_we_o}, 4'h0)
        $display("test skip done");
    endtask
    initial begin
        bad_count = 0;
        checked = 0;
        rstn_i = 1'b0;
        instr_i = 16'h0000;
        btr_file_model_i.carry_q = 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        `CHK(phase_o, 2'h0)
        t_invert();
        t_rlnc();
        t_rrc();
        t_skip();
        results();
    end
endmodule
